// file: rtl/hsc_pkg.sv
// shared constants, register map and state types of the high-speed counter bank
`default_nettype none

package hsc_pkg;

  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int NUM_CNT  = 21;
  localparam int NUM_SC   = 11;
  localparam int NUM_DC   = 5;
  localparam int NUM_QC   = 5;
  localparam int NUM_IN   = 8;
  localparam int CW       = 32;
  localparam int AW       = 10;
  localparam int FIRST_DC = 11;
  localparam int FIRST_QC = 16;
  localparam int IDX_DC2  = 13;
  localparam int IDX_QC2  = 18;
  localparam int IDX_QC3  = 19;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] OFS_CTRL    = 10'h000;
  localparam logic [AW-1:0] OFS_ACTIVE  = 10'h004;
  localparam logic [AW-1:0] OFS_DIRSEL  = 10'h008;
  localparam logic [AW-1:0] OFS_CLEAR   = 10'h00C;
  localparam logic [AW-1:0] OFS_CONTACT = 10'h010;
  localparam logic [AW-1:0] OFS_DIRSTAT = 10'h014;
  localparam logic [AW-1:0] OFS_GPIN    = 10'h018;
  localparam logic [AW-1:0] OFS_RSTSTAT = 10'h01C;
  localparam logic [1:0]    PAGE_VALUE  = 2'h1;
  localparam logic [1:0]    PAGE_SETV   = 2'h2;
  localparam int            DIR_QC_LSB  = 8;

  // ----------------------------------------------------------------
  // pin allocation: {p0, p1, reset pin, start pin}, PIN_NONE = unused
  // ----------------------------------------------------------------
  localparam logic [3:0] PIN_NONE = 4'h8;
  localparam logic [NUM_CNT-1:0][15:0] ALLOC = {
    16'h3457, 16'h0126, 16'h3458, 16'h0128, 16'h0188,
    16'h3457, 16'h0126, 16'h3458, 16'h0128, 16'h0188,
    16'h2837, 16'h0816, 16'h4858, 16'h2838, 16'h0818,
    16'h5888, 16'h4888, 16'h3888, 16'h2888, 16'h1888, 16'h0888};
  localparam logic [15:0] ALT_PAIR34 = 16'h3488;
  localparam logic [15:0] ALT_PAIR67 = 16'h6788;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic          read;
    logic          write;
    logic [AW-1:0] address;
    logic [CW-1:0] writedata;
    logic [3:0]    byteenable;
  } avm_req_t;

  typedef struct packed {
    logic [CW-1:0] readdata;
    logic          waitrequest;
  } avm_rsp_t;

  typedef struct packed {
    logic          alt_assign;
    logic          software_reset_condition;
    logic          counter_enable_condition;
  } ctrl_t;

  typedef struct packed {
    logic [CW-1:0] value;
    logic          contact;
    logic          down;
    logic          cleared;
  } cnt_state_t;

  typedef struct packed {
    logic [NUM_IN-1:0]              sync1;
    logic [NUM_IN-1:0]              sync2;
    logic [NUM_IN-1:0]              prev;
    logic [NUM_IN-1:0]              gpin;
    ctrl_t                          ctrl;
    logic [NUM_CNT-1:0]             active;
    logic [NUM_CNT-1:0]             clr_pend;
    logic [NUM_SC-1:0]              direction_select_bits;
    logic [NUM_CNT-1:0][CW-1:0]     setv;
    avm_rsp_t                       rsp;
  } hsc_state_t;

  localparam cnt_state_t CNT_RST = '{value: 32'h0, contact: 1'b0, down: 1'b0,
                                     cleared: 1'b0};
  localparam hsc_state_t STATE_RST = '{
    sync1: 8'h00, sync2: 8'h00, prev: 8'h00, gpin: 8'h00,
    ctrl: 3'h0, active: 21'h0, clr_pend: 21'h0,
    direction_select_bits: 11'h0, setv: '0,
    rsp: '{readdata: 32'h0, waitrequest: 1'b1}};

endpackage

`default_nettype wire

// file: rtl/hsc_counter.sv
// one 32-bit ring counter with compare contact and retained state
`timescale 1ns/100ps
`default_nettype none

module hsc_counter (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  input  wire logic               cold_start,
  // count control
  input  wire logic               step_up,
  input  wire logic               step_dn,
  input  wire logic               clear,
  input  wire logic               load,
  input  wire logic [31:0]        load_val,
  input  wire logic [31:0]        set_val,
  // state
  output var  hsc_pkg::cnt_state_t st
);
  import hsc_pkg::*;

  cnt_state_t st_r;
  cnt_state_t st_nxt;
  logic       up_only;
  logic       dn_only;

  assign up_only = step_up & ~step_dn & ~clear & ~load;
  assign dn_only = step_dn & ~step_up & ~clear & ~load;
  assign st      = st_r;

  // the contact never gates the count; simultaneous up and down cancel
  always_comb begin
    st_nxt = st_r;
    if (clear) begin
      st_nxt.value   = 32'h0000_0000;
      st_nxt.contact = 1'b0;
      st_nxt.cleared = 1'b1;
    end else if (load) begin
      st_nxt.value = load_val;
    end else if (step_up ^ step_dn) begin
      st_nxt.cleared = 1'b0;
      if (step_up) begin
        st_nxt.value = st_r.value + 32'h0000_0001;
        st_nxt.down  = 1'b0;
        if (st_nxt.value == set_val) begin
          st_nxt.contact = 1'b1;
        end
      end else begin
        st_nxt.value = st_r.value - 32'h0000_0001;
        st_nxt.down  = 1'b1;
        if (st_r.value == set_val) begin
          st_nxt.contact = 1'b0;
        end
      end
    end
  end

  // a warm reset keeps value, contact and reset status across power loss
  always_ff @(posedge clk) begin
    if (reset && cold_start) begin
      st_r <= CNT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  chk_wrap_up: assert property (@(posedge clk) disable iff (reset)
    up_only && st_r.value == 32'h7FFF_FFFF |=> st_r.value == 32'h8000_0000)
    else $error("up wrap failed");
  chk_wrap_down: assert property (@(posedge clk) disable iff (reset)
    dn_only && st_r.value == 32'h8000_0000 |=> st_r.value == 32'h7FFF_FFFF)
    else $error("down wrap failed");
  chk_step_one: assert property (@(posedge clk) disable iff (reset)
    up_only |=> st_r.value == $past(st_r.value) + 32'h0000_0001)
    else $error("up step not one");
  chk_contact_set: assert property (@(posedge clk) disable iff (reset)
    up_only && st_r.value + 32'h0000_0001 == set_val ##1 set_val == $past(set_val)
    |-> st_r.contact)
    else $error("contact not set at set value");
  chk_contact_drop: assert property (@(posedge clk) disable iff (reset)
    dn_only && st_r.value == set_val |=> !st_r.contact && st_r.down)
    else $error("contact not cleared below set value");
  chk_clear_zero: assert property (@(posedge clk) disable iff (reset)
    clear |=> st_r.value == 32'h0 && !st_r.contact && st_r.cleared)
    else $error("clear did not zero counter");

endmodule

`default_nettype wire

// file: rtl/hsc_bank.sv
// high-speed counter bank: input sync, pin allocation, decode and register slave
//
// Implementation choices: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/100ps
`default_nettype none

module hsc_bank (
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           reset,
  input  wire logic                           cold_start,
  // input terminals in_0 to in_7
  input  wire logic [hsc_pkg::NUM_IN-1:0]     in_pins,
  // register bus
  input  wire hsc_pkg::avm_req_t              bus_req,
  output var  hsc_pkg::avm_rsp_t              bus_rsp,
  // status out
  output logic [hsc_pkg::NUM_CNT-1:0]         contact_out,
  output logic [hsc_pkg::NUM_IN-1:0]          gp_in,
  output logic [hsc_pkg::NUM_DC-1:0]          dual_direction_status_bits,
  output logic [hsc_pkg::NUM_QC-1:0]          quad_direction_status_bits
);
  import hsc_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  hsc_state_t         st_r;
  hsc_state_t         st_nxt;
  cnt_state_t         cnt [NUM_CNT];
  logic [NUM_IN-1:0]  used_by [NUM_CNT];
  logic [NUM_IN-1:0]  rise;
  logic [NUM_IN:0]    lvl_x;
  logic [NUM_IN:0]    rise_x;
  logic [NUM_CNT-1:0] up_s;
  logic [NUM_CNT-1:0] dn_s;
  logic [NUM_CNT-1:0] clr_s;
  logic [NUM_CNT-1:0] load_s;
  logic [NUM_CNT-1:0] ext_rst;
  logic [NUM_CNT-1:0] contact_v;
  logic [NUM_CNT-1:0] cleared_v;
  logic [CW-1:0]      wmask;
  logic [CW-1:0]      rd_data;
  logic [NUM_IN-1:0]  used;
  logic               req;
  logic               acc_wr;
  logic [4:0]         widx;
  logic               widx_ok;

  // edges are taken on the second sync stage only, so a pin bounce
  // that straddles a clock edge yields one step, not two
  assign rise   = st_r.sync2 & ~st_r.prev;
  assign lvl_x  = {1'b0, st_r.sync2};
  assign rise_x = {1'b0, rise};

  assign req     = bus_req.read | bus_req.write;
  assign acc_wr  = bus_req.write & ~st_r.rsp.waitrequest;
  assign widx    = bus_req.address[6:2];
  assign widx_ok = (bus_req.address[7] == 1'b0) && (widx < 5'(NUM_CNT));
  assign wmask   = {{8{bus_req.byteenable[3]}}, {8{bus_req.byteenable[2]}},
                    {8{bus_req.byteenable[1]}}, {8{bus_req.byteenable[0]}}};

  // ----------------------------------------------------------------
  // per-counter allocation, decode and counter
  // ----------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CNT; gi++) begin : g_cnt
      logic [15:0] map;
      logic [3:0]  p0;
      logic [3:0]  p1;
      logic [3:0]  pr;
      logic [3:0]  ps;
      logic        en;
      logic [8:0]  pin_m;

      // the alternate map drops reset and start on the switched channels
      if (gi == IDX_DC2 || gi == IDX_QC2) begin : g_alt34
        assign map = st_r.ctrl.alt_assign ? ALT_PAIR34 : ALLOC[gi];
        chk_alt_bare: assert property (@(posedge clk) disable iff (reset)
          st_r.ctrl.alt_assign |-> pr == PIN_NONE && ps == PIN_NONE)
          else $error("alternate map kept reset or start");
      end else if (gi == IDX_QC3) begin : g_alt67
        assign map = st_r.ctrl.alt_assign ? ALT_PAIR67 : ALLOC[gi];
        chk_alt_bare: assert property (@(posedge clk) disable iff (reset)
          st_r.ctrl.alt_assign |-> pr == PIN_NONE && ps == PIN_NONE)
          else $error("alternate map kept reset or start");
      end else begin : g_std
        assign map = ALLOC[gi];
      end

      assign p0 = map[15:12];
      assign p1 = map[11:8];
      assign pr = map[7:4];
      assign ps = map[3:0];

      assign en = st_r.ctrl.counter_enable_condition & st_r.active[gi]
                & ((ps == PIN_NONE) | lvl_x[ps]);

      if (gi < FIRST_DC) begin : g_single
        assign up_s[gi] = en & rise_x[p0] & ~st_r.direction_select_bits[gi];
        assign dn_s[gi] = en & rise_x[p0] & st_r.direction_select_bits[gi];

        chk_single_down: assert property (@(posedge clk) disable iff (reset)
          dn_s[gi] && !clr_s[gi] && !load_s[gi]
          |=> cnt[gi].value == $past(cnt[gi].value) - 32'h0000_0001
              && cnt[gi].down)
          else $error("single counter did not step down");
      end else if (gi < FIRST_QC) begin : g_dual
        assign up_s[gi] = en & rise_x[p0];
        assign dn_s[gi] = en & rise_x[p1];

        chk_dual_step: assert property (@(posedge clk) disable iff (reset)
          up_s[gi] && !dn_s[gi] && !clr_s[gi] && !load_s[gi]
          |=> cnt[gi].value == $past(cnt[gi].value) + 32'h0000_0001)
          else $error("dual counter did not step up");
      end else begin : g_quad
        // phase A rising while B low means A leads: count up
        assign up_s[gi] = en & rise_x[p0] & ~lvl_x[p1];
        assign dn_s[gi] = en & rise_x[p0] & lvl_x[p1];

        chk_quad_lead: assert property (@(posedge clk) disable iff (reset)
          en && rise_x[p0] && lvl_x[p1]
          |-> dn_s[gi] && !up_s[gi])
          else $error("phase lead not decoded as down");
      end

      // the reset pin acts on its level, so it needs no program cycle
      assign ext_rst[gi] = st_r.active[gi] & lvl_x[pr];
      assign clr_s[gi]   = ext_rst[gi] | st_r.clr_pend[gi];
      assign load_s[gi]  = acc_wr & (bus_req.address[9:8] == PAGE_VALUE)
                         & widx_ok & (widx == 5'(gi));

      assign pin_m = (9'h001 << p0) | (9'h001 << p1) | (9'h001 << pr) | (9'h001 << ps);
      assign used_by[gi] = st_r.active[gi] ? pin_m[NUM_IN-1:0] : 8'h00;
      assign contact_v[gi] = cnt[gi].contact;
      assign cleared_v[gi] = cnt[gi].cleared;

      hsc_counter u_cnt (
        .clk        (clk),
        .reset      (reset),
        .cold_start (cold_start),
        .step_up    (up_s[gi]),
        .step_dn    (dn_s[gi]),
        .clear      (clr_s[gi]),
        .load       (load_s[gi]),
        .load_val   ((cnt[gi].value & ~wmask) | (bus_req.writedata & wmask)),
        .set_val    (st_r.setv[gi]),
        .st         (cnt[gi])
      );

      chk_ext_reset: assert property (@(posedge clk) disable iff (reset)
        ext_rst[gi] |=> cnt[gi].value == 32'h0 && !cnt[gi].contact)
        else $error("external reset did not clear counter");
      chk_start_gate: assert property (@(posedge clk) disable iff (reset)
        ps != PIN_NONE && !lvl_x[ps] |-> !up_s[gi] && !dn_s[gi])
        else $error("counted before start input");

      chk_enable_gate: assert property (@(posedge clk) disable iff (reset)
        !st_r.ctrl.counter_enable_condition || !st_r.active[gi]
        |-> !up_s[gi] && !dn_s[gi])
        else $error("counted while disabled");
    end
  endgenerate

  // ----------------------------------------------------------------
  // status outputs
  // ----------------------------------------------------------------
  generate
    for (gi = 0; gi < NUM_DC; gi++) begin : g_dir
      assign dual_direction_status_bits[gi] = cnt[FIRST_DC + gi].down;
      assign quad_direction_status_bits[gi] = cnt[FIRST_QC + gi].down;

      // direction flags follow the last lone step; a clear or load keeps them
      chk_dual_status: assert property (@(posedge clk) disable iff (reset)
        (up_s[FIRST_DC + gi] ^ dn_s[FIRST_DC + gi])
        && !clr_s[FIRST_DC + gi] && !load_s[FIRST_DC + gi]
        |=> dual_direction_status_bits[gi] == $past(dn_s[FIRST_DC + gi]))
        else $error("dual direction status wrong");

      chk_quad_status: assert property (@(posedge clk) disable iff (reset)
        (up_s[FIRST_QC + gi] ^ dn_s[FIRST_QC + gi])
        && !clr_s[FIRST_QC + gi] && !load_s[FIRST_QC + gi]
        |=> quad_direction_status_bits[gi] == $past(dn_s[FIRST_QC + gi]))
        else $error("quad direction status wrong");
    end
  endgenerate

  assign contact_out = contact_v;
  assign gp_in       = st_r.gpin;
  assign bus_rsp     = st_r.rsp;

  always_comb begin
    used = 8'h00;
    for (int i = 0; i < NUM_CNT; i++) begin
      used = used | used_by[i];
    end
  end

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always_comb begin
    rd_data = 32'h0000_0000;
    if (bus_req.address[9:8] == PAGE_VALUE) begin
      if (widx_ok) begin
        rd_data = cnt[widx].value;
      end
    end else if (bus_req.address[9:8] == PAGE_SETV) begin
      if (widx_ok) begin
        rd_data = st_r.setv[widx];
      end
    end else begin
      unique case (bus_req.address)
        OFS_CTRL:    rd_data = {29'h0, st_r.ctrl};
        OFS_ACTIVE:  rd_data = {11'h0, st_r.active};
        OFS_DIRSEL:  rd_data = {21'h0, st_r.direction_select_bits};
        OFS_CONTACT: rd_data = {11'h0, contact_v};
        OFS_DIRSTAT: rd_data = {19'h0, quad_direction_status_bits, 3'h0,
                                dual_direction_status_bits};
        OFS_GPIN:    rd_data = {24'h0, st_r.gpin};
        OFS_RSTSTAT: rd_data = {11'h0, cleared_v};
        default:     rd_data = 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.sync1 = in_pins;
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev  = st_r.sync2;
    st_nxt.gpin  = st_r.sync2 & ~used;
    st_nxt.clr_pend = 21'h0;

    // one wait cycle per access, then one cycle with waitrequest low
    if (req && st_r.rsp.waitrequest) begin
      st_nxt.rsp.waitrequest = 1'b0;
      if (bus_req.read) begin
        st_nxt.rsp.readdata = rd_data;
      end
    end else begin
      st_nxt.rsp.waitrequest = 1'b1;
    end

    if (acc_wr) begin
      if (bus_req.address[9:8] == PAGE_SETV) begin
        if (widx_ok) begin
          st_nxt.setv[widx] = (st_r.setv[widx] & ~wmask) | (bus_req.writedata & wmask);
        end
      end else if (bus_req.address[9:8] == 2'h0) begin
        unique case (bus_req.address)
          OFS_CTRL: begin
            if (bus_req.byteenable[0]) begin
              st_nxt.ctrl = bus_req.writedata[2:0];
            end
          end
          OFS_ACTIVE: begin
            st_nxt.active = (st_r.active & wmask[20:0])
                          ^ (st_r.active & wmask[20:0])
                          | (st_r.active & ~wmask[20:0])
                          | (bus_req.writedata[20:0] & wmask[20:0]);
          end
          OFS_DIRSEL: begin
            st_nxt.direction_select_bits = (st_r.direction_select_bits & ~wmask[10:0])
                                         | (bus_req.writedata[10:0] & wmask[10:0]);
          end
          OFS_CLEAR: begin
            // the clear command only acts while the reset condition is on
            if (st_r.ctrl.software_reset_condition) begin
              st_nxt.clr_pend = bus_req.writedata[20:0] & wmask[20:0];
            end
          end
          default: begin
          end
        endcase
      end
    end

    if (reset) begin
      st_nxt = STATE_RST;
    end
  end

  always_ff @(posedge clk) begin
    st_r <= st_nxt;
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  chk_gpin_mask: assert property (@(posedge clk) disable iff (reset)
    ##1 gp_in == ($past(st_r.sync2) & ~$past(used)))
    else $error("general input not masked by allocation");
  chk_bus_answer: assert property (@(posedge clk) disable iff (reset)
    req && bus_rsp.waitrequest |=> !bus_rsp.waitrequest ##1 bus_rsp.waitrequest)
    else $error("bus answer not one cycle");
  chk_edge_once: assert property (@(posedge clk) disable iff (reset)
    rise[0] |=> !rise[0])
    else $error("edge seen twice");

  chk_sync_delay: assert property (@(posedge clk) disable iff (reset)
    ##2 st_r.sync2 == $past(in_pins, 2))
    else $error("input not two flops deep");

  // the clear command lands one edge after the edge that accepts its write
  chk_clear_gate: assert property (@(posedge clk) disable iff (reset)
    acc_wr && bus_req.address == OFS_CLEAR && !st_r.ctrl.software_reset_condition
    |=> st_r.clr_pend == 21'h0)
    else $error("clear acted without reset condition");

  chk_clear_apply: assert property (@(posedge clk) disable iff (reset)
    acc_wr && bus_req.address == OFS_CLEAR && st_r.ctrl.software_reset_condition
    && bus_req.writedata[0] && bus_req.byteenable[0]
    |=> ##2 cnt[0].value == 32'h0000_0000 && cnt[0].cleared)
    else $error("clear command did not zero counter");

endmodule

`default_nettype wire

// file: verification/hsc_pulse_src.sv
// pulse source and two-phase encoder model driving the input terminals
`timescale 1ns/100ps
`default_nettype none

module hsc_pulse_src (
  // clock
  input  wire logic       clk,
  // terminals in_0 to in_7
  output var  logic [7:0] pins
);
  initial pins = 8'h00;

  // ----------------------------------------------------------------
  // drive tasks, entered and left right after a rising edge
  // ----------------------------------------------------------------
  // every level stands 3 clocks, well under a quarter of the clock rate
  task automatic hold();
    repeat (3) @(posedge clk);
  endtask

  task automatic level(input int p, input logic v);
    pins[p] <= v;
    hold();
  endtask

  task automatic pulse(input int p, input int n);
    repeat (n) begin
      level(p, 1'b1);
      level(p, 1'b0);
    end
  endtask

  // one encoder cycle: phase a leads going up, phase b leads going down
  task automatic quad(input int a, input int b, input logic dn);
    level(dn ? b : a, 1'b1);
    level(dn ? a : b, 1'b1);
    level(dn ? b : a, 1'b0);
    level(dn ? a : b, 1'b0);
  endtask

  task automatic set_all(input logic [7:0] v);
    pins <= v;
    hold();
  endtask
endmodule

`default_nettype wire

// file: verification/hsc_bank_tb.sv
// self-checking bench of the high-speed counter bank
`timescale 1ns/100ps
`default_nettype none

module hsc_bank_tb;
  import hsc_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic               clk;
  logic               reset;
  logic               cold_start;
  avm_req_t           bus_req;
  avm_rsp_t           bus_rsp;
  logic [NUM_IN-1:0]  in_pins;
  logic [NUM_CNT-1:0] contact_out;
  logic [NUM_IN-1:0]  gp_in;
  logic [NUM_DC-1:0]  dual_direction_status_bits;
  logic [NUM_QC-1:0]  quad_direction_status_bits;
  int                 error_cnt = 0;
  int                 n_checks = 0;
  int                 seed = 39917;
  logic [CW-1:0]      exp_q[$];
  string              name_q[$];
  logic [CW-1:0]      rv;

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  hsc_bank u_dut (
    .clk                        (clk),
    .reset                      (reset),
    .cold_start                 (cold_start),
    .in_pins                    (in_pins),
    .bus_req                    (bus_req),
    .bus_rsp                    (bus_rsp),
    .contact_out                (contact_out),
    .gp_in                      (gp_in),
    .dual_direction_status_bits (dual_direction_status_bits),
    .quad_direction_status_bits (quad_direction_status_bits)
  );

  hsc_pulse_src u_src (
    .clk  (clk),
    .pins (in_pins)
  );

  // ----------------------------------------------------------------
  // reporting
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic check(input string what, input logic [CW-1:0] exp,
                       input logic [CW-1:0] got);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  // ----------------------------------------------------------------
  // bus master
  // ----------------------------------------------------------------
  // request held until waitrequest is sampled low, released after that edge
  task automatic xfer(input logic w, input logic [AW-1:0] a, input logic [CW-1:0] d);
    int i;
    bus_req <= '{read: !w, write: w, address: a, writedata: d, byteenable: 4'hF};
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (bus_rsp.waitrequest === 1'b0) break;
    end
    if (i == 20) begin
      error_cnt++;
      $display("Error waitrequest expected 0 seen 1");
      complete_run();
    end
    bus_req <= '0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [AW-1:0] a, input logic [CW-1:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rd(input logic [AW-1:0] a, input logic [CW-1:0] e, input string nm);
    exp_q.push_back(e);
    name_q.push_back(nm);
    xfer(1'b0, a, '0);
  endtask

  function automatic logic [AW-1:0] va(input int i);
    return {PAGE_VALUE, 8'(4 * i)};
  endfunction

  // read data are compared at the edge where waitrequest is low
  always @(posedge clk) begin
    if (bus_req.read && bus_rsp.waitrequest === 1'b0) begin
      if (exp_q.size() == 0) begin
        error_cnt++;
        $display("Error readdata expected none seen %h", bus_rsp.readdata);
      end else
        check(name_q.pop_front(), exp_q.pop_front(), bus_rsp.readdata);
    end
  end

  initial begin
    repeat (60000) @(posedge clk);
    error_cnt++;
    $display("Error watchdog expected finish seen timeout");
    complete_run();
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    bus_req = '0;
    reset = 1'b1;
    cold_start = 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    cold_start <= 1'b0;
    repeat (2) @(posedge clk);
    rd(OFS_CTRL, 32'h0, "ctrl");
    rd(va(0), 32'h0, "value0");
    wr(10'h3FC, 32'hFFFFFFFF);
    rd(10'h3FC, 32'h0, "unmapped");
    $display("test reset done");
    wr(OFS_CTRL, 32'h1);
    wr(OFS_ACTIVE, 32'h1);
    wr({PAGE_SETV, 8'h00}, 32'h2);
    u_src.pulse(0, 3);
    rd(va(0), 32'h3, "sc0 up");
    rd(OFS_CONTACT, 32'h1, "contact set");
    check("contact_out", 32'h1, 32'(contact_out));
    wr(OFS_DIRSEL, 32'h1);
    u_src.pulse(0, 1);
    rd(va(0), 32'h2, "sc0 down");
    rd(OFS_CONTACT, 32'h1, "contact held");
    u_src.pulse(0, 1);
    rd(va(0), 32'h1, "sc0 below");
    rd(OFS_CONTACT, 32'h0, "contact clear");
    $display("test single done");
    wr(va(0), 32'h7FFFFFFF);
    wr(OFS_DIRSEL, 32'h0);
    u_src.pulse(0, 1);
    rd(va(0), 32'h80000000, "wrap up");
    wr(OFS_DIRSEL, 32'h1);
    u_src.pulse(0, 1);
    rd(va(0), 32'h7FFFFFFF, "wrap down");
    wr(va(0), 32'h1);
    wr(OFS_DIRSEL, 32'h0);
    u_src.pulse(0, 1);
    wr(OFS_CLEAR, 32'h1);
    rd(va(0), 32'h2, "clear ignored");
    wr(OFS_CTRL, 32'h3);
    wr(OFS_CLEAR, 32'h1);
    rd(va(0), 32'h0, "clear value");
    rd(OFS_CONTACT, 32'h0, "clear contact");
    rd(OFS_RSTSTAT, 32'h1, "clear status");
    $display("test clear done");
    rv = $random(seed);
    wr(va(1), rv);
    rd(va(1), rv, "value1");
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    rd(va(1), rv, "retained");
    rd(OFS_RSTSTAT, 32'h1, "retained status");
    rd(OFS_CTRL, 32'h0, "ctrl warm");
    $display("test retention done");
    wr(OFS_CTRL, 32'h1);
    rv = $random(seed);
    u_src.set_all(rv[7:0]);
    rd(OFS_GPIN, {24'h0, rv[7:0]}, "gpin idle");
    wr(OFS_ACTIVE, 32'h1);
    u_src.hold();
    rd(OFS_GPIN, {24'h0, rv[7:1], 1'b0}, "gpin masked");
    check("gp_in", {24'h0, rv[7:1], 1'b0}, 32'(gp_in));
    u_src.set_all(8'h00);
    $display("test gpin done");
    wr(OFS_ACTIVE, 32'h1 << 11);
    u_src.pulse(0, 2);
    u_src.pulse(1, 1);
    rd(va(11), 32'h1, "dc0 value");
    rd(OFS_DIRSTAT, 32'h1, "dc0 down");
    check("dual_dir", 32'h1, 32'(dual_direction_status_bits));
    u_src.pulse(0, 1);
    rd(OFS_DIRSTAT, 32'h0, "dc0 up");
    wr(OFS_ACTIVE, 32'h1 << 12);
    u_src.pulse(0, 2);
    rd(va(12), 32'h2, "dc1 value");
    u_src.level(2, 1'b1);
    u_src.hold();
    rd(va(12), 32'h0, "dc1 ext reset");
    u_src.level(2, 1'b0);
    $display("test dual done");
    wr(OFS_ACTIVE, 32'h1 << 9);
    u_src.pulse(0, 2);
    rd(va(9), 32'h0, "sc9 no start");
    u_src.level(6, 1'b1);
    u_src.pulse(0, 2);
    rd(va(9), 32'h2, "sc9 started");
    u_src.level(6, 1'b0);
    $display("test start done");
    wr(OFS_ACTIVE, 32'h1 << 16);
    repeat (2) u_src.quad(0, 1, 1'b0);
    u_src.quad(0, 1, 1'b1);
    rd(va(16), 32'h1, "qc0 value");
    rd(OFS_DIRSTAT, 32'h100, "qc0 down");
    check("quad_dir", 32'h1, 32'(quad_direction_status_bits));
    wr(OFS_CTRL, 32'h5);
    wr(OFS_ACTIVE, 32'h1 << 19);
    repeat (2) u_src.quad(6, 7, 1'b0);
    rd(va(19), 32'h2, "qc3 alt");
    rd(OFS_DIRSTAT, 32'h100, "qc3 up");
    check("quad_dir", 32'h1, 32'(quad_direction_status_bits));
    $display("test quad done");
    repeat (4) @(posedge clk);
    complete_run();
  end
endmodule

`default_nettype wire
